//--- hw/ltc_params.svh
// Constants for the LIN/CAN transceiver control block
`ifndef LTC_PARAMS_SVH
`define LTC_PARAMS_SVH

`define LTC_CLK_MHZ          20
`define LTC_LIN_WAKE_NS      90000
`define LTC_LIN_TO_NS        6000000
`define LTC_CAN_TO_NS        650000
`define LTC_CAN_WAKE_DOM_NS  2500
`define LTC_CAN_WAKE_REC_NS  2500

// Least times round up to whole cycles
`define LTC_NS2CYC(ns)       (((ns) * `LTC_CLK_MHZ + 999) / 1000)

`define LTC_LIN_WAKE_CYC     `LTC_NS2CYC(`LTC_LIN_WAKE_NS)
`define LTC_LIN_TO_CYC       `LTC_NS2CYC(`LTC_LIN_TO_NS)
`define LTC_CAN_TO_CYC       `LTC_NS2CYC(`LTC_CAN_TO_NS)
`define LTC_CAN_DOM_CYC      `LTC_NS2CYC(`LTC_CAN_WAKE_DOM_NS)
`define LTC_CAN_REC_CYC      `LTC_NS2CYC(`LTC_CAN_WAKE_REC_NS)

`define LTC_MODE_NORMAL      2'h0
`define LTC_MODE_STANDBY     2'h1
`define LTC_MODE_SLEEP       2'h2

`define LTC_EV_WIDTH         3
`define LTC_FIFO_DEPTH       4
`define LTC_NUM_EV           5

`endif

//--- hw/ltc_pkg.sv
// Types shared by the LIN/CAN transceiver control block
package ltc_pkg;

  typedef enum logic [2:0] {
    LTC_EV_LIN_TIMEOUT = 3'h0,
    LTC_EV_CAN_TIMEOUT = 3'h1,
    LTC_EV_CAN_FAIL    = 3'h2,
    LTC_EV_LIN_WAKE    = 3'h3,
    LTC_EV_CAN_WAKE    = 3'h4
  } ltc_event_t;

  typedef enum logic [2:0] {
    LTC_CW_IDLE,
    LTC_CW_DOM1,
    LTC_CW_REC1,
    LTC_CW_DOM2,
    LTC_CW_REC2
  } ltc_can_wake_t;

endpackage

//--- hw/ltc_stream_if.sv
// Valid/ready stream carrier between the control block and its event FIFO
`timescale 1ns/1ns
interface ltc_stream_if #(
  parameter int WIDTH = 3
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hw/ltc_fifo.sv
// Event FIFO with a registered output stage
`timescale 1ns/1ns
module ltc_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
) (
  input  wire logic   clk,     // Block clock
  input  wire logic   rst,     // Synchronous reset, active high
  ltc_stream_if.snk   push,    // Filling side
  ltc_stream_if.src   pop      // Draining side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic             do_push;
  logic             do_pop;

  // Full only counts the array; the output stage is an extra slot
  assign push.ready = (count_reg < (AW+1)'(DEPTH));
  assign do_push    = push.valid && push.ready;
  assign do_pop     = (count_reg != '0) && (!out_valid_reg || pop.ready);
  assign pop.valid  = out_valid_reg;
  assign pop.data   = out_data_reg;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= push.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (do_pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem_reg[rd_ptr_reg];
    end else if (pop.ready) begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule

//--- hw/ltc_top.sv
// LIN and CAN transceiver digital control: mode gating, time-outs, wakeups
//
// Summary of operation
// - Normal mode: LIN bus follows transmit, receive mirrored
// - Main supply under-voltage holds LIN bus recessive
// - Low power: LIN transmit ignored, receive high, low once a LIN wake is flagged
// - LIN wake: dominant 90 us then rising edge
// - LIN wake enabled by default, software may disable
// - LIN dominant time-out enabled by software setting
// - LIN time-out starts on falling edge, latches flag
// - LIN transmit blocked until flag read-cleared
// - Slope select: normal default, low when set
// - CAN disable and listen-only settings gate transceiver
// - CAN transmit low over 650 us latches flag
// - CAN transmit blocked until flag read-cleared
// - CAN supply under-voltage forces recessive, receive high in normal mode
// - CAN supply recovery reconnects pins immediately
// - CAN wake: two dominant/recessive pairs, 2.5 us
// - Low power: CAN receive follows low-power receiver, low once a CAN wake is flagged
// - CAN wake enable sampled on low-power entry
// - Low power: CAN split pin high-impedance
// - Sticky CAN supply failure flag until cleared
// - Live CAN supply under-voltage status bit
`timescale 1ns/1ns
`include "ltc_params.svh"
module ltc_top #(
  parameter int LIN_TO_CYC  = `LTC_LIN_TO_CYC,
  parameter int CAN_TO_CYC  = `LTC_CAN_TO_CYC,
  parameter int FIFO_DEPTH  = `LTC_FIFO_DEPTH
) (
  input  wire logic       clk,                          // 20 MHz block clock
  input  wire logic       rst,                          // Synchronous reset, high
  input  wire logic [1:0] dev_mode,                     // Normal, standby or sleep
  input  wire logic       main_battery_supply_uv,       // Main supply under-voltage
  input  wire logic       lin_transmit_input,           // LIN transmit from controller
  input  wire logic       lin_bus_level,                // LIN bus comparator, 1 recessive
  input  wire logic       lin_timeout_enable,           // Enables LIN dominant time-out
  input  wire logic       lin_wake_disable,             // Disables LIN wake detection
  input  wire logic       lin_slope_low_select,         // Selects low slope
  input  wire logic       lin_timeout_clear,            // Read-and-clear pulse, LIN time-out
  input  wire logic       lin_wake_clear,               // Read-and-clear pulse, LIN wake
  input  wire logic       can_transmit_input,           // CAN transmit from controller
  input  wire logic       can_bus_level,                // CAN main receiver, 1 recessive
  input  wire logic       can_lp_bus_level,             // CAN low-power receiver
  input  wire logic       can_transceiver_disable,      // Powers the CAN transceiver down
  input  wire logic       can_listen_only_select,       // Receive only
  input  wire logic       can_wake_disable,             // Disables CAN wake detection
  input  wire logic       can_supply_uv,                // CAN supply comparator
  input  wire logic       can_timeout_clear,            // Read-and-clear pulse, CAN time-out
  input  wire logic       can_fail_clear,               // Read-and-clear pulse, supply fail
  input  wire logic       can_wake_clear,               // Read-and-clear pulse, CAN wake
  input  wire logic       event_ready,                  // Event consumer ready
  output logic            lin_drive_dominant,           // Drive LIN bus dominant
  output logic            lin_receive_output,           // LIN receive to controller
  output logic            lin_slope_low,                // Low slope to the LIN stage
  output logic            lin_dominant_timeout_flag,    // Sticky LIN time-out
  output logic            lin_wake_flag,                // Sticky LIN wake source
  output logic            can_drive_dominant,           // Drive CAN bus dominant
  output logic            can_receive_output,           // CAN receive to controller
  output logic            can_powered,                  // CAN transceiver powered
  output logic            can_split_pin_oe_n,           // Split pin enable, high is Z
  output logic            can_dominant_timeout_flag,    // Sticky CAN time-out
  output logic            can_supply_undervoltage_live, // Unlatched supply status
  output logic            can_supply_fail_flag,         // Sticky supply failure
  output logic            can_wake_flag,                // Sticky CAN wake source
  output logic            event_valid,                  // Event record available
  output logic [2:0]      event_code                    // Event record code
);
  localparam int LW_CYC  = `LTC_LIN_WAKE_CYC;
  localparam int CD_CYC  = `LTC_CAN_DOM_CYC;
  localparam int CR_CYC  = `LTC_CAN_REC_CYC;
  localparam int LTW     = $clog2(LIN_TO_CYC + 1);
  localparam int CTW     = $clog2(CAN_TO_CYC + 1);
  localparam int LWW     = $clog2(LW_CYC + 1);
  localparam int CWW     = $clog2(((CD_CYC > CR_CYC) ? CD_CYC : CR_CYC) + 1);
  localparam int NEV     = `LTC_NUM_EV;

  function automatic logic is_low_power(input logic [1:0] m);
    is_low_power = (m == `LTC_MODE_STANDBY) || (m == `LTC_MODE_SLEEP);
  endfunction

  logic normal;
  logic low_power;
  logic can_active;

  assign normal     = (dev_mode == `LTC_MODE_NORMAL);
  assign low_power  = is_low_power(dev_mode);
  assign can_active = normal && !can_transceiver_disable;

  // ---------------- LIN dominant time-out ----------------
  logic           lin_tx_prev_reg;
  logic           lin_to_run_reg;
  logic [LTW-1:0] lin_to_cnt_reg;
  logic           lin_to_flag_reg;
  logic           lin_to_hit;

  assign lin_to_hit = lin_to_run_reg && !lin_transmit_input
                      && (lin_to_cnt_reg >= LTW'(LIN_TO_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      lin_tx_prev_reg <= 1'b1;
      lin_to_run_reg  <= 1'b0;
      lin_to_cnt_reg  <= '0;
    end else begin
      lin_tx_prev_reg <= lin_transmit_input;
      if (!lin_timeout_enable || lin_transmit_input) begin
        lin_to_run_reg <= 1'b0;
        lin_to_cnt_reg <= '0;
      end else if (lin_tx_prev_reg) begin
        lin_to_run_reg <= 1'b1;
        lin_to_cnt_reg <= '0;
      end else if (lin_to_run_reg && !lin_to_hit) begin
        lin_to_cnt_reg <= lin_to_cnt_reg + 1'b1;
      end
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_to_flag_reg <= 1'b0;
    end else if (lin_timeout_enable && lin_to_hit) begin
      lin_to_flag_reg <= 1'b1;
    end else if (lin_timeout_clear) begin
      lin_to_flag_reg <= 1'b0;
    end
  end

  // ---------------- LIN wake filter ----------------
  logic           lin_bus_prev_reg;
  logic [LWW-1:0] lin_dom_cnt_reg;
  logic           lin_wake_flag_reg;
  logic           lin_wake_hit;

  assign lin_wake_hit = low_power && !lin_wake_disable && !lin_bus_prev_reg
                        && lin_bus_level && (lin_dom_cnt_reg >= LWW'(LW_CYC));

  always_ff @(posedge clk) begin
    if (rst) begin
      lin_bus_prev_reg <= 1'b1;
      lin_dom_cnt_reg  <= '0;
    end else begin
      lin_bus_prev_reg <= lin_bus_level;
      if (!low_power || lin_bus_level) begin
        lin_dom_cnt_reg <= '0;
      end else if (lin_dom_cnt_reg < LWW'(LW_CYC)) begin
        lin_dom_cnt_reg <= lin_dom_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lin_wake_flag_reg <= 1'b0;
    end else if (lin_wake_hit) begin
      lin_wake_flag_reg <= 1'b1;
    end else if (lin_wake_clear) begin
      lin_wake_flag_reg <= 1'b0;
    end
  end

  // ---------------- LIN pin outputs ----------------
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_drive_dominant <= 1'b0;
      lin_receive_output <= 1'b1;
      lin_slope_low      <= 1'b0;
    end else begin
      lin_drive_dominant <= normal && !main_battery_supply_uv
                            && !lin_to_flag_reg && !lin_to_hit
                            && !lin_transmit_input;
      if (normal) begin
        lin_receive_output <= lin_bus_level;
      end else begin
        lin_receive_output <= !(lin_wake_flag_reg || lin_wake_hit);
      end
      lin_slope_low <= lin_slope_low_select;
    end
  end

  // ---------------- CAN dominant time-out and supply ----------------
  logic           can_to_run_reg;
  logic [CTW-1:0] can_to_cnt_reg;
  logic           can_to_flag_reg;
  logic           can_fail_flag_reg;
  logic           can_to_hit;

  assign can_to_hit = can_to_run_reg && !can_transmit_input
                      && (can_to_cnt_reg >= CTW'(CAN_TO_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      can_to_run_reg <= 1'b0;
      can_to_cnt_reg <= '0;
    end else if (can_transmit_input || !can_active) begin
      can_to_run_reg <= 1'b0;
      can_to_cnt_reg <= '0;
    end else if (!can_to_run_reg) begin
      can_to_run_reg <= 1'b1;
      can_to_cnt_reg <= '0;
    end else if (!can_to_hit) begin
      can_to_cnt_reg <= can_to_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      can_to_flag_reg <= 1'b0;
    end else if (can_to_hit) begin
      can_to_flag_reg <= 1'b1;
    end else if (can_timeout_clear) begin
      can_to_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      can_fail_flag_reg <= 1'b0;
    end else if (can_active && can_supply_uv) begin
      can_fail_flag_reg <= 1'b1;
    end else if (can_fail_clear) begin
      can_fail_flag_reg <= 1'b0;
    end
  end

  // ---------------- CAN wake detector ----------------
  ltc_pkg::ltc_can_wake_t cw_state_reg;
  logic [CWW-1:0]         cw_cnt_reg;
  logic                   cw_bus_prev_reg;
  logic                   low_power_prev_reg;
  logic                   can_wake_en_reg;
  logic                   can_wake_flag_reg;
  logic                   cw_done;
  logic                   cw_dom;

  assign cw_dom  = !can_lp_bus_level;
  assign cw_done = (cw_state_reg == ltc_pkg::LTC_CW_REC2) && !cw_dom
                   && (cw_cnt_reg >= CWW'(CR_CYC - 1));

  // The setting counts only if it is in place in the first low-power cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      low_power_prev_reg <= 1'b0;
      can_wake_en_reg    <= 1'b1;
    end else begin
      low_power_prev_reg <= low_power;
      if (low_power && !low_power_prev_reg) begin
        can_wake_en_reg <= !can_wake_disable;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cw_state_reg    <= ltc_pkg::LTC_CW_IDLE;
      cw_cnt_reg      <= '0;
      cw_bus_prev_reg <= 1'b0;
    end else if (!low_power || !can_wake_en_reg || cw_done) begin
      cw_state_reg    <= ltc_pkg::LTC_CW_IDLE;
      cw_cnt_reg      <= '0;
      cw_bus_prev_reg <= cw_dom;
    end else begin
      cw_bus_prev_reg <= cw_dom;
      if (cw_dom != cw_bus_prev_reg) begin
        cw_cnt_reg <= '0;
      end else if (cw_cnt_reg < CWW'(CD_CYC)) begin
        cw_cnt_reg <= cw_cnt_reg + 1'b1;
      end
      case (cw_state_reg)
        ltc_pkg::LTC_CW_IDLE: begin
          if (cw_dom) begin
            cw_state_reg <= ltc_pkg::LTC_CW_DOM1;
          end
        end
        ltc_pkg::LTC_CW_DOM1, ltc_pkg::LTC_CW_DOM2: begin
          if (!cw_dom) begin
            if (cw_cnt_reg >= CWW'(CD_CYC)) begin
              cw_state_reg <= (cw_state_reg == ltc_pkg::LTC_CW_DOM1) ?
                              ltc_pkg::LTC_CW_REC1 : ltc_pkg::LTC_CW_REC2;
            end else begin
              cw_state_reg <= ltc_pkg::LTC_CW_IDLE;
            end
          end
        end
        ltc_pkg::LTC_CW_REC1, ltc_pkg::LTC_CW_REC2: begin
          if (cw_dom) begin
            if (cw_state_reg == ltc_pkg::LTC_CW_REC1 && cw_cnt_reg >= CWW'(CR_CYC)) begin
              cw_state_reg <= ltc_pkg::LTC_CW_DOM2;
            end else begin
              cw_state_reg <= ltc_pkg::LTC_CW_DOM1;       // Short recessive restarts
            end
          end
        end
        default: begin
          cw_state_reg <= ltc_pkg::LTC_CW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      can_wake_flag_reg <= 1'b0;
    end else if (cw_done) begin
      can_wake_flag_reg <= 1'b1;
    end else if (can_wake_clear) begin
      can_wake_flag_reg <= 1'b0;
    end
  end

  // ---------------- CAN pin outputs ----------------
  always_ff @(posedge clk) begin
    if (rst) begin
      can_drive_dominant           <= 1'b0;
      can_receive_output           <= 1'b1;
      can_powered                  <= 1'b0;
      can_split_pin_oe_n           <= 1'b1;
      can_supply_undervoltage_live <= 1'b0;
    end else begin
      // Supply status is combinational in the path, so recovery reconnects at once
      can_drive_dominant <= can_active && !can_supply_uv
                            && !can_listen_only_select
                            && !can_to_flag_reg && !can_to_hit
                            && !can_transmit_input;
      if (low_power) begin
        can_receive_output <= can_lp_bus_level && !(can_wake_flag_reg || cw_done);
      end else if (can_active && !can_supply_uv) begin
        can_receive_output <= can_bus_level;
      end else begin
        can_receive_output <= 1'b1;
      end
      can_powered        <= can_active;
      can_split_pin_oe_n <= !can_active;
      can_supply_undervoltage_live <= can_supply_uv;
    end
  end

  // ---------------- Event recording through the FIFO ----------------
  ltc_stream_if #(.WIDTH(`LTC_EV_WIDTH)) ev_in ();
  ltc_stream_if #(.WIDTH(`LTC_EV_WIDTH)) ev_out ();

  logic [NEV-1:0] ev_rise;
  logic [NEV-1:0] ev_pend_reg;
  logic [NEV-1:0] ev_pick;
  logic [2:0]     ev_code;

  assign ev_rise = {cw_done,
                    lin_wake_hit && !lin_wake_flag_reg,
                    can_active && can_supply_uv && !can_fail_flag_reg,
                    can_to_hit && !can_to_flag_reg,
                    lin_timeout_enable && lin_to_hit && !lin_to_flag_reg};

  // Lowest pending index goes first; a full FIFO keeps the rest pending
  always_comb begin
    ev_pick = '0;
    ev_code = 3'h0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (ev_pend_reg[i]) begin
        ev_pick = NEV'(1) << i;
        ev_code = 3'(i);
      end
    end
  end

  assign ev_in.valid  = (ev_pend_reg != '0);
  assign ev_in.data   = ev_code;
  assign ev_out.ready = event_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_pend_reg <= '0;
    end else begin
      ev_pend_reg <= (ev_pend_reg & ~((ev_in.valid && ev_in.ready) ? ev_pick : '0))
                     | ev_rise;
    end
  end

  ltc_fifo #(
    .WIDTH (`LTC_EV_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_ev_fifo (
    .clk  (clk),
    .rst  (rst),
    .push (ev_in),
    .pop  (ev_out)
  );

  assign event_valid = ev_out.valid;
  assign event_code  = ev_out.data;

  assign lin_dominant_timeout_flag = lin_to_flag_reg;
  assign lin_wake_flag             = lin_wake_flag_reg;
  assign can_dominant_timeout_flag = can_to_flag_reg;
  assign can_supply_fail_flag      = can_fail_flag_reg;
  assign can_wake_flag             = can_wake_flag_reg;
endmodule

//--- tb/ltc_top_asserts.sv
// Port-level assertions for the transceiver control block
`timescale 1ns/1ns
module ltc_top_asserts (
  input wire logic       clk,                          // Clock
  input wire logic       rst,                          // Reset
  input wire logic [1:0] dev_mode,                     // Mode
  input wire logic       main_battery_supply_uv,       // Main uv
  input wire logic       lin_timeout_clear,            // LIN clear
  input wire logic       can_transceiver_disable,      // CAN off
  input wire logic       can_listen_only_select,       // Listen only
  input wire logic       can_supply_uv,                // CAN uv
  input wire logic       lin_drive_dominant,           // LIN drive
  input wire logic       lin_receive_output,           // LIN receive
  input wire logic       lin_dominant_timeout_flag,    // LIN flag
  input wire logic       lin_wake_flag,                // LIN wake
  input wire logic       can_drive_dominant,           // CAN drive
  input wire logic       can_receive_output,           // CAN receive
  input wire logic       can_split_pin_oe_n,           // Split enable
  input wire logic       can_supply_undervoltage_live  // Live uv
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence lin_wake_seen;
    $rose(lin_wake_flag);
  endsequence
  sequence can_blocked;
    can_transceiver_disable || can_listen_only_select || can_supply_uv;
  endsequence
  a_lin_uv_quiet: assert property (main_battery_supply_uv |=> !lin_drive_dominant)
    else $error("LIN driven in uv");
  a_lin_lp_quiet: assert property (dev_mode != 2'h0 |=> !lin_drive_dominant)
    else $error("LIN driven in low power");
  a_lin_to_block: assert property (lin_dominant_timeout_flag |-> !lin_drive_dominant)
    else $error("LIN driven after timeout");
  a_lin_to_hold: assert property (lin_dominant_timeout_flag && !lin_timeout_clear
    |=> lin_dominant_timeout_flag) else $error("LIN flag lost");
  a_can_tx_gate: assert property (can_blocked |=> !can_drive_dominant)
    else $error("CAN driven while gated");
  a_can_rx_high: assert property (dev_mode == 2'h0 && (can_transceiver_disable
    || can_supply_uv) |=> can_receive_output) else $error("CAN rx not high");
  a_split_idle: assert property (dev_mode != 2'h0 |=> can_split_pin_oe_n)
    else $error("Split driven in low power");
  a_uv_live_track: assert property (1'b1 |=>
    can_supply_undervoltage_live == $past(can_supply_uv)) else $error("Live uv wrong");
  a_lin_wake_rx: assert property (lin_wake_seen |-> !lin_receive_output)
    else $error("LIN wake without request");
endmodule
bind ltc_top ltc_top_asserts u_chk (.*);

//--- tb/ltc_evt_sink.sv
// Controller-side consumer of the event stream
`timescale 1ns/1ns
module ltc_evt_sink (
  input  wire logic       clk,         // Clock
  input  wire logic       stall,       // Holds ready low
  input  wire logic       event_valid, // Event offered
  input  wire logic [2:0] event_code,  // Event code
  output logic            event_ready  // Taking events
);
  logic [2:0] got[$];
  assign event_ready = !stall;
  always @(posedge clk) begin
    if (event_valid && event_ready) begin
      got.push_back(event_code);
    end
  end
endmodule

//--- tb/test_lin_can_transceiver_control.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/1ns
`define CHK(act, exp, msg) begin compares++; if ((act) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %0t %s", $time, msg); end end
// Clear pulses are one-cycle strobes; a macro avoids a nonblocking write through a ref argument
`define PULSE(s) begin @(posedge clk) s <= 1'b1; @(posedge clk) s <= 1'b0; end
module test_lin_can_transceiver_control;
  logic       clk = 1'b0, rst = 1'b1, stall = 1'b1;
  logic [1:0] dev_mode = 2'h0;
  logic       main_battery_supply_uv = 1'b0, lin_transmit_input = 1'b1, lin_bus_level = 1'b1;
  logic       lin_timeout_enable = 1'b0, lin_wake_disable = 1'b0, lin_slope_low_select = 1'b0;
  logic       lin_timeout_clear = 1'b0, lin_wake_clear = 1'b0, can_transmit_input = 1'b1;
  logic       can_bus_level = 1'b1, can_lp_bus_level = 1'b1, can_transceiver_disable = 1'b0;
  logic       can_listen_only_select = 1'b0, can_wake_disable = 1'b0, can_supply_uv = 1'b0;
  logic       can_timeout_clear = 1'b0, can_fail_clear = 1'b0, can_wake_clear = 1'b0;
  logic       event_ready, lin_drive_dominant, lin_receive_output, lin_slope_low, lin_wake_flag;
  logic       lin_dominant_timeout_flag, can_drive_dominant, can_receive_output, can_powered;
  logic       can_split_pin_oe_n, can_dominant_timeout_flag, can_supply_undervoltage_live;
  logic       can_supply_fail_flag, can_wake_flag, event_valid;
  logic [2:0] event_code;
  logic [2:0] exp_codes [5] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4};
  int         error_cnt = 0, compares = 0, cyc_cnt = 0;
  // Short time-outs keep the run brief
  ltc_top #(.LIN_TO_CYC(20), .CAN_TO_CYC(20)) i_dut (.*);
  ltc_evt_sink i_sink (.*);
  always #25 clk = ~clk;
  task automatic close_out;
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 8000) begin
      error_cnt++;
      close_out;
    end
  end
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_lin;
    @(posedge clk) lin_transmit_input <= 1'b0;
    lin_bus_level <= 1'b0;
    st(2);
    `CHK(lin_drive_dominant, 1'b1, "lin tx")
    `CHK(lin_receive_output, 1'b0, "lin rx")
    `CHK(lin_slope_low, 1'b0, "slope default")
    @(posedge clk) main_battery_supply_uv <= 1'b1;
    lin_slope_low_select <= 1'b1;
    st(2);
    `CHK(lin_drive_dominant, 1'b0, "lin uv")
    `CHK(lin_slope_low, 1'b1, "slope low")
    @(posedge clk) main_battery_supply_uv <= 1'b0;
    lin_transmit_input <= 1'b1;
    lin_bus_level <= 1'b1;
  endtask
  task automatic t_lin_to;
    @(posedge clk) lin_timeout_enable <= 1'b1;
    @(posedge clk) lin_transmit_input <= 1'b0;
    st(18);
    `CHK(lin_dominant_timeout_flag, 1'b0, "lin early")
    st(3);
    `CHK(lin_dominant_timeout_flag, 1'b1, "lin flag")
    `CHK(lin_drive_dominant, 1'b0, "lin forced")
    @(posedge clk) lin_transmit_input <= 1'b1;
    @(posedge clk) lin_transmit_input <= 1'b0;
    st(2);
    `CHK(lin_drive_dominant, 1'b0, "lin blocked")
    `PULSE(lin_timeout_clear)
    st(2);
    `CHK(lin_dominant_timeout_flag, 1'b0, "lin cleared")
    `CHK(lin_drive_dominant, 1'b1, "lin free")
    @(posedge clk) lin_transmit_input <= 1'b1;
    lin_timeout_enable <= 1'b0;
  endtask
  task automatic t_can;
    @(posedge clk) can_transmit_input <= 1'b0;
    can_bus_level <= 1'b0;
    st(2);
    `CHK({can_drive_dominant, can_receive_output, can_split_pin_oe_n}, 3'h4, "can on")
    @(posedge clk) can_listen_only_select <= 1'b1;
    st(2);
    `CHK({can_drive_dominant, can_receive_output}, 2'h0, "listen")
    @(posedge clk) can_listen_only_select <= 1'b0;
    can_transceiver_disable <= 1'b1;
    st(2);
    `CHK({can_powered, can_receive_output, can_split_pin_oe_n}, 3'h3, "can off")
    @(posedge clk) can_transceiver_disable <= 1'b0;
    can_supply_uv <= 1'b1;
    st(2);
    `CHK({can_drive_dominant, can_receive_output}, 2'h1, "can uv")
    `CHK(can_supply_undervoltage_live, 1'b1, "uv live")
    @(posedge clk) can_supply_uv <= 1'b0;
    st(2);
    `CHK({can_drive_dominant, can_receive_output}, 2'h2, "can back")
    `CHK(can_supply_fail_flag, 1'b1, "fail sticky")
    @(posedge clk) can_transmit_input <= 1'b1;
    can_bus_level <= 1'b1;
    `PULSE(can_fail_clear)
    st(1);
    `CHK(can_supply_fail_flag, 1'b0, "fail cleared")
  endtask
  task automatic t_can_to;
    @(posedge clk) can_transmit_input <= 1'b0;
    st(17);
    `CHK({can_dominant_timeout_flag, can_drive_dominant}, 2'h1, "can early")
    st(5);
    `CHK({can_dominant_timeout_flag, can_drive_dominant}, 2'h2, "can flag")
    @(posedge clk) can_transmit_input <= 1'b1;
    @(posedge clk) can_transmit_input <= 1'b0;
    st(2);
    `CHK(can_drive_dominant, 1'b0, "can blocked")
    @(posedge clk) can_transmit_input <= 1'b1;
    `PULSE(can_timeout_clear)
    st(1);
    `CHK(can_dominant_timeout_flag, 1'b0, "can cleared")
  endtask
  task automatic t_lin_wake;
    @(posedge clk) dev_mode <= 2'h1;
    lin_transmit_input <= 1'b0;
    st(2);
    `CHK({lin_drive_dominant, lin_receive_output}, 2'h1, "lin standby")
    `CHK(can_split_pin_oe_n, 1'b1, "split standby")
    // A dominant phase short of the filter must not wake; one past the filter must
    for (int n = 1000; n <= 1810; n += 810) begin
      @(posedge clk) lin_bus_level <= 1'b0;
      st(n);
      @(posedge clk) lin_bus_level <= 1'b1;
      st(2);
      `CHK(lin_wake_flag, n > 1800, "lin wake")
    end
    `CHK(lin_receive_output, 1'b0, "lin request")
    @(posedge clk) lin_transmit_input <= 1'b1;
    `PULSE(lin_wake_clear)
    st(1);
    `CHK({lin_wake_flag, lin_receive_output}, 2'h1, "lin wake clear")
  endtask
  task automatic t_can_wake;
    @(posedge clk) dev_mode <= 2'h2;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) can_lp_bus_level <= i[0];
      st(55);
      if (i < 3) `CHK(can_receive_output, i[0], "lp follow")
    end
    `CHK({can_wake_flag, can_receive_output}, 2'h2, "can wake")
    @(posedge clk) dev_mode <= 2'h0;
    `PULSE(can_wake_clear)
    st(1);
    `CHK(can_wake_flag, 1'b0, "can wake clear")
  endtask
  task automatic t_events;
    // Consumer stalled so far: five records fill the queue and output stage
    `CHK(event_valid, 1'b1, "event held")
    @(posedge clk) stall <= 1'b0;
    st(10);
    `CHK(i_sink.got.size(), 5, "event count")
    for (int i = 0; i < 5 && i < i_sink.got.size(); i++) `CHK(i_sink.got[i], exp_codes[i], "code")
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    st(2);
    t_lin;
    t_lin_to;
    t_can;
    t_can_to;
    t_lin_wake;
    t_can_wake;
    t_events;
    close_out;
  end
endmodule
